// ### rtl/pm1_event_defs.vh
// Offsets, bit positions, reset values and timing counts of the fixed-event block.
`ifndef PM1_EVENT_DEFS_VH
`define PM1_EVENT_DEFS_VH

// Register offsets within the block, in system I/O space.
`define OFS_STATUS_LOW      3'h0
`define OFS_STATUS_HIGH     3'h1
`define OFS_ENABLE_LOW      3'h2
`define OFS_ENABLE_HIGH     3'h3

// Low status and low enable bit positions.
`define BIT_PM_TIMER        0
`define BIT_GLOBAL_RELEASE  5

// High status bit positions; press and alarm are also the high enable bit positions.
`define BIT_BUTTON_PRESS    0
`define BIT_RTC_ALARM       2
`define BIT_BUTTON_OVERRIDE 3
`define BIT_WAKE            7

// Reset values after the standby power-on reset.
`define ENABLE_LOW_RESET    8'h00
`define ENABLE_HIGH_RESET   8'h00
`define STATUS_RESET        1'b0
`define READ_IDLE_VALUE     8'h00

// Timer counter bit whose toggles set the timer flag.
`define PM_TIMER_MSB        23

// Button hold time, clock rate and the cycle count they give (4000 ms at 50000 kHz).
`define CLK_FREQ_KHZ        50000
`define BTN_HOLD_TIME_MS    4000
`define BTN_HOLD_CYCLES     28'hBEBC200
`define BTN_HOLD_WIDTH      28

`endif

// ### rtl/button_hold_timer.v
// Counter that measures how long the power button has been held.
`timescale 1ns/1ps
`include "pm1_event_defs.vh"

module button_hold_timer #(
   parameter [`BTN_HOLD_WIDTH-1:0] HOLD_CYCLES = `BTN_HOLD_CYCLES
) (
   // Clock, reset and enable.
   input  wire clk_sys_in,
   input  wire reset_in,
   input  wire ce_in,
   // Button level and override arming.
   input  wire button_in,
   input  wire arm_in,
   // One-cycle pulse when the hold runs beyond the limit.
   output wire fire_out
);

   reg [`BTN_HOLD_WIDTH-1:0] count_r;
   reg                       done_r;
   reg                       fire_r;

   // The count restarts whenever the button is released, and fires at most once per press.
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         count_r <= {`BTN_HOLD_WIDTH{1'b0}};
         done_r  <= 1'b0;
         fire_r  <= 1'b0;
      end else if (ce_in) begin
         fire_r <= 1'b0;
         if (!button_in) begin
            count_r <= {`BTN_HOLD_WIDTH{1'b0}};
            done_r  <= 1'b0;
         end else if (!done_r) begin
            if (count_r == HOLD_CYCLES) begin
               done_r <= 1'b1;
               fire_r <= arm_in;
            end else begin
               count_r <= count_r + {{(`BTN_HOLD_WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   assign fire_out = fire_r;

endmodule

// ### rtl/pm1_event_status_enable.v
// Fixed-event status flags, their enables and the SCI request of the power block.
`timescale 1ns/1ps
`include "pm1_event_defs.vh"

module pm1_event_status_enable #(
   parameter [`BTN_HOLD_WIDTH-1:0] HOLD_CYCLES = `BTN_HOLD_CYCLES
) (
   // Clock, reset and enable.
   input  wire        clk_sys_in,
   input  wire        reset_in,
   input  wire        ce_in,
   // System I/O access, offset already relative to the block base.
   input  wire [2:0]  io_offset_in,
   input  wire        io_sel_in,
   input  wire        io_rd_in,
   input  wire        io_wr_in,
   input  wire [7:0]  io_wdata_in,
   output wire [7:0]  io_rdata_out,
   output wire        io_hit_out,
   // Event sources.
   input  wire        rtc_alarm2_in,
   input  wire        power_button_in,
   input  wire        pm_timer_bit_in,
   input  wire        firmware_release_request_in,
   input  wire        resume_event_in,
   input  wire        suspended_in,
   input  wire        main_supply_control_n_in,
   // Control bits held by the neighbouring control register.
   input  wire        sci_gate_enable_in,
   input  wire        button_override_enable_in,
   // Results.
   output wire        sci_out,
   output wire        wake_to_on_out,
   output wire        soft_off_request_out,
   output wire        firmware_release_clear_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   localparam [0:0] WAKE_IDLE  = 1'b0;
   localparam [0:0] WAKE_ARMED = 1'b1;

   reg  [7:0] enable_low_r;
   reg  [7:0] enable_high_r;
   reg        pm_timer_flag_r;
   reg        global_release_flag_r;
   reg        button_press_flag_r;
   reg        rtc_alarm_flag_r;
   reg        button_override_flag_r;
   reg        wake_flag_r;
   reg  [0:0] wake_state_r;
   reg  [0:0] wake_state_nxt;
   reg        timer_bit_prev_r;
   reg        timer_bit_valid_r;
   reg        supply_prev_r;
   reg        sci_r;
   reg        sci_nxt;
   reg  [7:0] rdata_r;
   reg  [7:0] rdata_nxt;
   reg        soft_off_r;
   reg        release_clear_r;

   wire       access_ok;
   wire       wr_status_low;
   wire       wr_status_high;
   wire       wr_enable_low;
   wire       wr_enable_high;
   wire       timer_toggle;
   wire       supply_fall;
   wire       override_fire;
   wire       wake_set;
   wire       clr_timer;
   wire       clr_global;
   wire       clr_press;
   wire       clr_rtc;
   wire       clr_override;
   wire       clr_wake;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.
   // Next value of a sticky flag; the hardware set beats a software clear.
   function next_flag;
      input cur;
      input set;
      input clr;
      begin
         if (set) begin
            next_flag = 1'b1;
         end else if (clr) begin
            next_flag = 1'b0;
         end else begin
            next_flag = cur;
         end
      end
   endfunction

   // True when the access addresses one of the four registers of this block.
   function is_mapped;
      input [2:0] ofs;
      begin
         is_mapped = (ofs == `OFS_STATUS_LOW) || (ofs == `OFS_STATUS_HIGH) ||
                     (ofs == `OFS_ENABLE_LOW) || (ofs == `OFS_ENABLE_HIGH);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Access decode.
   assign access_ok      = io_sel_in && is_mapped(io_offset_in);
   assign io_hit_out     = access_ok;
   assign wr_status_low  = access_ok && io_wr_in && (io_offset_in == `OFS_STATUS_LOW);
   assign wr_status_high = access_ok && io_wr_in && (io_offset_in == `OFS_STATUS_HIGH);
   assign wr_enable_low  = access_ok && io_wr_in && (io_offset_in == `OFS_ENABLE_LOW);
   assign wr_enable_high = access_ok && io_wr_in && (io_offset_in == `OFS_ENABLE_HIGH);

   // A written zero leaves every flag alone.
   assign clr_timer    = wr_status_low  && io_wdata_in[`BIT_PM_TIMER];
   assign clr_global   = wr_status_low  && io_wdata_in[`BIT_GLOBAL_RELEASE];
   assign clr_press    = wr_status_high && io_wdata_in[`BIT_BUTTON_PRESS];
   assign clr_rtc      = wr_status_high && io_wdata_in[`BIT_RTC_ALARM];
   assign clr_override = wr_status_high && io_wdata_in[`BIT_BUTTON_OVERRIDE];
   assign clr_wake     = wr_status_high && io_wdata_in[`BIT_WAKE] &&
                         !main_supply_control_n_in;

   ////////////////////////////////////////////////////////////////////////////
   // Button hold measurement.
   button_hold_timer #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) u_hold (
      .clk_sys_in  (clk_sys_in),
      .reset_in    (reset_in),
      .ce_in       (ce_in),
      .button_in   (power_button_in),
      .arm_in      (button_override_enable_in),
      .fire_out    (override_fire)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on the timer bit and the supply control.
   // The first timer-bit sample after reset only primes its history, so no false toggle; the supply history resets high.
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         timer_bit_prev_r  <= 1'b0;
         timer_bit_valid_r <= 1'b0;
         supply_prev_r     <= 1'b1;
      end else if (ce_in) begin
         timer_bit_prev_r  <= pm_timer_bit_in;
         timer_bit_valid_r <= 1'b1;
         supply_prev_r     <= main_supply_control_n_in;
      end
   end

   assign timer_toggle = timer_bit_valid_r && (pm_timer_bit_in != timer_bit_prev_r);
   assign supply_fall  = supply_prev_r && !main_supply_control_n_in;

   ////////////////////////////////////////////////////////////////////////////
   // Resume tracking.
   // A resume event seen while suspended is held until the supply turns on.
   always @* begin
      wake_state_nxt = wake_state_r;
      case (wake_state_r)
         WAKE_IDLE: begin
            if (suspended_in && resume_event_in) begin
               wake_state_nxt = WAKE_ARMED;
            end
         end
         WAKE_ARMED: begin
            if (supply_fall) begin
               wake_state_nxt = WAKE_IDLE;
            end
         end
         default: begin
            wake_state_nxt = WAKE_IDLE;
         end
      endcase
   end

   assign wake_set = (wake_state_r == WAKE_ARMED) && supply_fall;

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         wake_state_r <= WAKE_IDLE;
      end else if (ce_in) begin
         wake_state_r <= wake_state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags.
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         pm_timer_flag_r        <= `STATUS_RESET;
         global_release_flag_r  <= `STATUS_RESET;
         button_press_flag_r    <= `STATUS_RESET;
         rtc_alarm_flag_r       <= `STATUS_RESET;
         button_override_flag_r <= `STATUS_RESET;
         wake_flag_r            <= `STATUS_RESET;
      end else if (ce_in) begin
         pm_timer_flag_r       <= next_flag(pm_timer_flag_r, timer_toggle, clr_timer);
         global_release_flag_r <= next_flag(global_release_flag_r,
                                            firmware_release_request_in, clr_global);
         rtc_alarm_flag_r      <= next_flag(rtc_alarm_flag_r, rtc_alarm2_in, clr_rtc);
         button_override_flag_r <= next_flag(button_override_flag_r,
                                             override_fire, clr_override);
         wake_flag_r           <= next_flag(wake_flag_r, wake_set, clr_wake);
         // The override clear outranks the level set of a still-held button.
         if (override_fire) begin
            button_press_flag_r <= 1'b0;
         end else begin
            button_press_flag_r <= next_flag(button_press_flag_r,
                                             power_button_in, clr_press);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable registers.
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         enable_low_r  <= `ENABLE_LOW_RESET;
         enable_high_r <= `ENABLE_HIGH_RESET;
      end else if (ce_in) begin
         if (wr_enable_low) begin
            enable_low_r <= io_wdata_in;
         end
         if (wr_enable_high) begin
            enable_high_r <= io_wdata_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data.
   // Only implemented bits are returned; every reserved position reads zero.
   always @* begin
      rdata_nxt = `READ_IDLE_VALUE;
      case (io_offset_in)
         `OFS_STATUS_LOW: begin
            rdata_nxt[`BIT_PM_TIMER]       = pm_timer_flag_r;
            rdata_nxt[`BIT_GLOBAL_RELEASE] = global_release_flag_r;
         end
         `OFS_STATUS_HIGH: begin
            rdata_nxt[`BIT_BUTTON_PRESS]    = button_press_flag_r;
            rdata_nxt[`BIT_RTC_ALARM]       = rtc_alarm_flag_r;
            rdata_nxt[`BIT_BUTTON_OVERRIDE] = button_override_flag_r;
            rdata_nxt[`BIT_WAKE]            = wake_flag_r;
         end
         `OFS_ENABLE_LOW: begin
            rdata_nxt[`BIT_PM_TIMER]       = enable_low_r[`BIT_PM_TIMER];
            rdata_nxt[`BIT_GLOBAL_RELEASE] = enable_low_r[`BIT_GLOBAL_RELEASE];
         end
         `OFS_ENABLE_HIGH: begin
            rdata_nxt[`BIT_BUTTON_PRESS] = enable_high_r[`BIT_BUTTON_PRESS];
            rdata_nxt[`BIT_RTC_ALARM]    = enable_high_r[`BIT_RTC_ALARM];
         end
         default: begin
            rdata_nxt = `READ_IDLE_VALUE;
         end
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         rdata_r <= `READ_IDLE_VALUE;
      end else if (ce_in) begin
         if (access_ok && io_rd_in) begin
            rdata_r <= rdata_nxt;
         end else if (io_rd_in) begin
            rdata_r <= `READ_IDLE_VALUE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // SCI request.
   always @* begin
      sci_nxt = 1'b0;
      if (pm_timer_flag_r && enable_low_r[`BIT_PM_TIMER]) begin
         sci_nxt = 1'b1;
      end
      if (global_release_flag_r && enable_low_r[`BIT_GLOBAL_RELEASE]) begin
         sci_nxt = 1'b1;
      end
      if (rtc_alarm_flag_r && enable_high_r[`BIT_RTC_ALARM]) begin
         sci_nxt = 1'b1;
      end
      if (button_press_flag_r && enable_high_r[`BIT_BUTTON_PRESS]) begin
         sci_nxt = 1'b1;
      end
      if (!sci_gate_enable_in) begin
         sci_nxt = 1'b0;
      end
   end

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         sci_r <= 1'b0;
      end else if (ce_in) begin
         sci_r <= sci_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Side effects toward the neighbouring logic.
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         soft_off_r      <= 1'b0;
         release_clear_r <= 1'b0;
      end else if (ce_in) begin
         soft_off_r      <= override_fire;
         release_clear_r <= clr_global;
      end
   end

   assign io_rdata_out               = rdata_r;
   assign sci_out                    = sci_r;
   assign wake_to_on_out             = wake_flag_r;
   assign soft_off_request_out       = soft_off_r;
   assign firmware_release_clear_out = release_clear_r;

endmodule

// ### sim/pm1_event_status_enable_props.sv
// Port-level checker for the fixed-event status and enable block.
`timescale 1ns/1ps
`include "pm1_event_defs.vh"

module pm1_event_status_enable_props #(
   parameter [`BTN_HOLD_WIDTH-1:0] HOLD_CYCLES = 28'h0000010
) (
   // Clock, reset and enable.
   input wire logic       clk_sys_in,
   input wire logic       reset_in,
   input wire logic       ce_in,
   // Register access.
   input wire logic [2:0] io_offset_in,
   input wire logic       io_sel_in,
   input wire logic       io_rd_in,
   input wire logic       io_wr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic [7:0] io_rdata_out,
   // Events and results.
   input wire logic       rtc_alarm2_in,
   input wire logic       power_button_in,
   input wire logic       pm_timer_bit_in,
   input wire logic       main_supply_control_n_in,
   input wire logic       sci_gate_enable_in,
   input wire logic       sci_out,
   input wire logic       wake_to_on_out,
   input wire logic       soft_off_request_out,
   input wire logic       firmware_release_clear_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   wire rd_hi  = ce_in & io_sel_in & io_rd_in & (io_offset_in == `OFS_STATUS_HIGH);
   wire rd_lo  = ce_in & io_sel_in & io_rd_in & (io_offset_in == `OFS_STATUS_LOW);
   wire rel_wr = ce_in & io_sel_in & io_wr_in & (io_offset_in == `OFS_STATUS_LOW)
                 & io_wdata_in[`BIT_GLOBAL_RELEASE];
   logic [`BTN_HOLD_WIDTH-1:0] hold_r;
   // Counts consecutive cycles with the button held.
   always @(posedge clk_sys_in) begin
      if (reset_in || !power_button_in)
         hold_r <= 28'h0000000;
      else if (ce_in)
         hold_r <= hold_r + 28'h0000001;
   end
   property p_gate;
      !sci_gate_enable_in && ce_in |=> !sci_out;
   endproperty
   a_gate: assert property (p_gate) else $error("sci while gated");
   property p_rtc;
      rd_hi && $past(rtc_alarm2_in) && $past(ce_in) && !$past(reset_in)
      |=> io_rdata_out[`BIT_RTC_ALARM];
   endproperty
   a_rtc: assert property (p_rtc) else $error("alarm flag missing");
   property p_timer;
      rd_lo && ($past(pm_timer_bit_in) != $past(pm_timer_bit_in, 2)) && $past(ce_in)
      && $past(ce_in, 2) && !$past(reset_in) && !$past(reset_in, 2)
      |=> io_rdata_out[`BIT_PM_TIMER];
   endproperty
   a_timer: assert property (p_timer) else $error("timer flag missing");
   property p_resv;
      rd_hi |=> io_rdata_out[6:4] == 3'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_hold;
      soft_off_request_out |-> $past(hold_r, 2) >= HOLD_CYCLES;
   endproperty
   a_hold: assert property (p_hold) else $error("override too early");
   property p_pulse;
      soft_off_request_out && ce_in |=> !soft_off_request_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("override pulse too long");
   property p_wake;
      wake_to_on_out && main_supply_control_n_in |=> wake_to_on_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake cleared while off");
   property p_rel;
      rel_wr |=> firmware_release_clear_out;
   endproperty
   a_rel: assert property (p_rel) else $error("release clear missing");
endmodule

// ### sim/io_host_model.sv
// Host model issuing single-cycle system I/O reads and writes.
`timescale 1ns/1ps

module io_host_model (
   // Clock.
   input  wire logic  clk_sys_in,
   // Access towards the block.
   output logic [2:0] io_offset_out,
   output logic       io_sel_out,
   output logic       io_rd_out,
   output logic       io_wr_out,
   output logic [7:0] io_wdata_out
);
   initial begin
      io_offset_out = 3'h7;
      io_sel_out = 1'b0;
      io_rd_out = 1'b0;
      io_wr_out = 1'b0;
      io_wdata_out = 8'h00;
   end
   task automatic write_reg(input logic [2:0] ofs, input logic [7:0] d);
      @(posedge clk_sys_in);
      io_offset_out <= ofs;
      io_wdata_out <= d;
      io_sel_out <= 1'b1;
      io_wr_out <= 1'b1;
      @(posedge clk_sys_in);
      io_sel_out <= 1'b0;
      io_wr_out <= 1'b0;
      io_wdata_out <= ~d;
   endtask
   task automatic read_reg(input logic [2:0] ofs);
      @(posedge clk_sys_in);
      io_offset_out <= ofs;
      io_sel_out <= 1'b1;
      io_rd_out <= 1'b1;
      @(posedge clk_sys_in);
      io_sel_out <= 1'b0;
      io_rd_out <= 1'b0;
      io_offset_out <= ~ofs;
   endtask
endmodule

// ### sim/pm1_event_status_enable_tb.sv
// Self-checking bench for the fixed-event status and enable block.
`timescale 1ns/1ps
`include "pm1_event_defs.vh"

module pm1_event_status_enable_tb;
   localparam [`BTN_HOLD_WIDTH-1:0] HOLD = 28'h0000010;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic ce_in = 1'b1;
   logic rtc_alarm2_in = 1'b0, power_button_in = 1'b0, pm_timer_bit_in = 1'b0;
   logic firmware_release_request_in = 1'b0, resume_event_in = 1'b0, suspended_in = 1'b0;
   logic main_supply_control_n_in = 1'b1, sci_gate_enable_in = 1'b0;
   logic button_override_enable_in = 1'b0;
   wire [2:0] io_offset_in;
   wire [7:0] io_wdata_in, io_rdata_out;
   wire io_sel_in, io_rd_in, io_wr_in, io_hit_out, sci_out, wake_to_on_out;
   wire soft_off_request_out, firmware_release_clear_out;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int offs = 0;
   integer seed = 32'h1D44DC4E;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   logic [7:0] d;

   pm1_event_status_enable #(.HOLD_CYCLES(HOLD)) dut_u (.*);
   io_host_model host_u (.clk_sys_in(clk_sys_in), .io_offset_out(io_offset_in),
      .io_sel_out(io_sel_in), .io_rd_out(io_rd_in), .io_wr_out(io_wr_in),
      .io_wdata_out(io_wdata_in));

   initial forever #10 clk_sys_in = ~clk_sys_in;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [2:0] ofs, input logic [7:0] exp);
      exp_q.push_back(exp);
      host_u.read_reg(ofs);
   endtask
   task automatic wr(input logic [2:0] ofs, input logic [7:0] dat);
      host_u.write_reg(ofs, dat);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic final_report;
      if (fail_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Read data appears the cycle after the strobe; oldest note is compared.
   always @(posedge clk_sys_in) begin
      if (rd_pend)
         chk(io_rdata_out, exp_q.pop_front());
      if (io_sel_in === 1'b1)
         chk({7'h00, io_hit_out}, {7'h00, io_offset_in < 3'h4});
      rd_pend <= io_sel_in & io_rd_in & ce_in;
      if (soft_off_request_out === 1'b1)
         offs <= offs + 1;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      ticks(6);
      reset_in <= 1'b0;
      sci_gate_enable_in <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd(3'(i), `READ_IDLE_VALUE);
      repeat (4) begin
         d = 8'($random(seed));
         wr(`OFS_ENABLE_LOW, d);
         wr(`OFS_ENABLE_HIGH, ~d);
         rd(`OFS_ENABLE_LOW, d & 8'h21);
         rd(`OFS_ENABLE_HIGH, ~d & 8'h05);
      end
      wr(`OFS_ENABLE_LOW, 8'h00);
      wr(`OFS_ENABLE_HIGH, 8'h04);
      rtc_alarm2_in <= 1'b1;
      rd(`OFS_STATUS_HIGH, 8'h04);
      rtc_alarm2_in <= 1'b0;
      ticks(1);
      chk(sci_out, 8'h01);
      sci_gate_enable_in <= 1'b0;
      ticks(2);
      chk(sci_out, 8'h00);
      sci_gate_enable_in <= 1'b1;
      wr(`OFS_STATUS_HIGH, 8'h00);
      rd(`OFS_STATUS_HIGH, 8'h04);
      wr(`OFS_STATUS_HIGH, 8'h04);
      rd(`OFS_STATUS_HIGH, 8'h00);
      chk(sci_out, 8'h00);
      wr(`OFS_ENABLE_LOW, 8'h01);
      pm_timer_bit_in <= 1'b1;
      ticks(3);
      chk(sci_out, 8'h01);
      wr(`OFS_ENABLE_LOW, 8'h00);
      ticks(2);
      chk(sci_out, 8'h00);
      wr(`OFS_STATUS_LOW, 8'h01);
      rd(`OFS_STATUS_LOW, 8'h00);
      pm_timer_bit_in <= 1'b0;
      rd(`OFS_STATUS_LOW, 8'h01);
      wr(`OFS_STATUS_LOW, 8'h01);
      firmware_release_request_in <= 1'b1;
      wr(`OFS_ENABLE_LOW, 8'h20);
      firmware_release_request_in <= 1'b0;
      ticks(2);
      chk(sci_out, 8'h01);
      rd(`OFS_STATUS_LOW, 8'h20);
      wr(`OFS_STATUS_LOW, 8'h20);
      ticks(1);
      chk(firmware_release_clear_out, 8'h01);
      rd(`OFS_STATUS_LOW, 8'h00);
      wr(`OFS_ENABLE_LOW, 8'h00);
      power_button_in <= 1'b1;
      ticks(1);
      power_button_in <= 1'b0;
      wr(`OFS_ENABLE_HIGH, 8'h01);
      ticks(2);
      chk(sci_out, 8'h01);
      rd(`OFS_STATUS_HIGH, 8'h01);
      wr(`OFS_STATUS_HIGH, 8'h01);
      wr(`OFS_ENABLE_HIGH, 8'h00);
      // Release lands on the override edge so the press flag stays cleared.
      button_override_enable_in <= 1'b1;
      power_button_in <= 1'b1;
      ticks(HOLD + 2);
      power_button_in <= 1'b0;
      ticks(3);
      rd(`OFS_STATUS_HIGH, 8'h08);
      chk(offs[7:0], 8'h01);
      wr(`OFS_STATUS_HIGH, 8'h08);
      button_override_enable_in <= 1'b0;
      power_button_in <= 1'b1;
      ticks(HOLD + 8);
      power_button_in <= 1'b0;
      ticks(2);
      rd(`OFS_STATUS_HIGH, 8'h01);
      chk(offs[7:0], 8'h01);
      wr(`OFS_STATUS_HIGH, 8'h01);
      suspended_in <= 1'b1;
      resume_event_in <= 1'b1;
      ticks(1);
      resume_event_in <= 1'b0;
      ticks(1);
      main_supply_control_n_in <= 1'b0;
      suspended_in <= 1'b0;
      ticks(3);
      chk(wake_to_on_out, 8'h01);
      rd(`OFS_STATUS_HIGH, 8'h80);
      main_supply_control_n_in <= 1'b1;
      wr(`OFS_STATUS_HIGH, 8'h80);
      rd(`OFS_STATUS_HIGH, 8'h80);
      main_supply_control_n_in <= 1'b0;
      wr(`OFS_STATUS_HIGH, 8'h00);
      rd(`OFS_STATUS_HIGH, 8'h80);
      wr(`OFS_STATUS_HIGH, 8'h80);
      rd(`OFS_STATUS_HIGH, 8'h00);
      ticks(4);
      chk(wake_to_on_out, 8'h00);
      chk(8'(exp_q.size()), 8'h00);
      final_report();
   end
endmodule

bind pm1_event_status_enable pm1_event_status_enable_props
   #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (.*);
